// ### inc/mps_pkg.sv
package mps_pkg;
    // apb register byte offsets
    localparam logic [7:0]  MPS_OFS_PERIOD = 8'h00;
    localparam logic [7:0]  MPS_OFS_MAXON  = 8'h04;
    localparam logic [7:0]  MPS_OFS_STATUS = 8'h08;
    localparam logic [7:0]  MPS_OFS_AVG    = 8'h0c;
    // reset values (cycles of clk)
    localparam logic [15:0] MPS_PERIOD_RST = 16'h0190;
    localparam logic [15:0] MPS_MAXON_RST  = 16'h0140;
    // status field positions
    localparam int          MPS_ST_CNT_LSB = 0;
    localparam int          MPS_ST_SERIAL  = 4;
    localparam int          MPS_ST_PARAL   = 5;
    localparam int          MPS_ST_EN      = 6;
    localparam int          MPS_ST_DRV_LSB = 8;
    // balance filter: shift per cycle, trim gain shift
    localparam int          MPS_FILT_SH    = 2;
    localparam int          MPS_TRIM_SH    = 1;
    localparam int          MPS_CH         = 4;
    // mode-select setup the outside must honour before enable rises
    localparam int          MPS_SEL_SETUP_NS = 1000;
    localparam int          MPS_CLK_NS       = 20;
    localparam int          MPS_SEL_SETUP_CYC =
        (MPS_SEL_SETUP_NS + MPS_CLK_NS - 1) / MPS_CLK_NS;
endpackage

// ### rtl/mps_sequencer.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
// Overview of operation
// R1 - interval timer period equals programmed switching period
// R2 - output low until crossing, high until back
// R3 - low commands low-side on, high high-side
// R4 - each phase rises at most once per interval
// R5 - alignment trip forces all active phases on
// R6 - sense pins tied high reduce channel count
// R7 - cycle spans successive terminations of one channel
// R8 - four channels fire 1-2-3-4 quarter-cycle apart
// R9 - three channels fire 1-2-3 third-cycle apart
// R10 - two channels: second phase half-cycle later
// R11 - sample active channel currents every cycle
// R12 - average is active sum over channel count
// R13 - filtered per-channel error trims pulse width
// R14 - enable low: both regulators off, sample select
// R15 - mode latched at enable rise, held while high
// R16 - select low latches serial code mode
// R17 - select high latches parallel code mode
// R18 - select stable one microsecond before enable rises
// R19 - parallel mode keeps north-bridge regulator off
// R20 - inactive phases low, no forcing, no averaging
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int CW = 12
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [MPS_CH-1:0]   modulator_cross,
    input  wire logic                transient_phase_alignment,
    input  wire logic                ch2_sense_neg,
    input  wire logic                ch3_sense_neg,
    input  wire logic                ch4_sense_neg,
    input  wire logic [MPS_CH*CW-1:0] ch_current,
    input  wire logic                enable,
    input  wire logic                mode_select_pin,
    output logic                     phase1_drive,
    output logic                     phase2_drive,
    output logic                     phase3_drive,
    output logic                     phase4_drive,
    output logic                     core_enable,
    output logic                     nb_enable,
    output logic                     serial_code_mode,
    output logic                     parallel_code_mode
);
    import mps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage one feeds stage two only
    logic [MPS_CH-1:0]    cross_s1_reg, cross_s2_reg;
    logic [5:0]           pin_s1_reg, pin_s2_reg;
    logic [MPS_CH*CW-1:0] cur_s1_reg, cur_s2_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            cross_s1_reg <= '0;
            cross_s2_reg <= '0;
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            cur_s1_reg   <= '0;
            cur_s2_reg   <= '0;
        end else begin
            cross_s1_reg <= modulator_cross;
            cross_s2_reg <= cross_s1_reg;
            pin_s1_reg   <= {mode_select_pin, enable, ch4_sense_neg,
                             ch3_sense_neg, ch2_sense_neg,
                             transient_phase_alignment};
            pin_s2_reg   <= pin_s1_reg;
            cur_s1_reg   <= ch_current;
            cur_s2_reg   <= cur_s1_reg;
        end
    end

    wire apa_s  = pin_s2_reg[0];
    wire sn2_s  = pin_s2_reg[1];
    wire sn3_s  = pin_s2_reg[2];
    wire sn4_s  = pin_s2_reg[3];
    wire en_s   = pin_s2_reg[4];
    wire sel_s  = pin_s2_reg[5];

    ////////////////////////////////////////////////////////////////////
    // channel count from sense pins tied high
    wire [2:0] nch = (sn4_s && sn3_s && sn2_s) ? 3'h1 :     // R6
                     (sn4_s && sn3_s)          ? 3'h2 :     // R6
                     sn4_s                     ? 3'h3 :     // R6
                                                 3'h4;
    wire [MPS_CH-1:0] active;
    genvar g;
    generate
        for (g = 0; g < MPS_CH; g++) begin : g_act
            assign active[g] = (3'(g) < nch);                // R20
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // mode latch on enable rise
    logic en_d_reg, run_reg, serial_reg, parallel_reg;
    wire  en_rise = en_s && !en_d_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            en_d_reg     <= 1'b0;
            run_reg      <= 1'b0;
            serial_reg   <= 1'b0;
            parallel_reg <= 1'b0;
        end else begin
            en_d_reg <= en_s;
            run_reg  <= en_s;                                // R14
            if (!en_s) begin
                serial_reg   <= 1'b0;
                parallel_reg <= 1'b0;
            end else if (en_rise) begin                      // R15
                serial_reg   <= !sel_s;                      // R16
                parallel_reg <= sel_s;                       // R17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state so every output is registered
    logic [15:0] period_reg, maxon_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg, pslverr_reg;
    logic [MPS_CH-1:0] drive_reg;
    logic [CW-1:0] avg_reg;

    wire acc      = psel && penable;
    wire hit_per  = (paddr == MPS_OFS_PERIOD);
    wire hit_max  = (paddr == MPS_OFS_MAXON);
    wire hit_st   = (paddr == MPS_OFS_STATUS);
    wire hit_avg  = (paddr == MPS_OFS_AVG);
    wire mapped   = hit_per || hit_max || hit_st || hit_avg;
    wire wr_done  = acc && pready_reg && pwrite && mapped;
    wire [31:0] status_word = 32'(
        ({24'h0, drive_reg} << MPS_ST_DRV_LSB) |
        ({31'h0, run_reg} << MPS_ST_EN) |
        ({31'h0, parallel_reg} << MPS_ST_PARAL) |
        ({31'h0, serial_reg} << MPS_ST_SERIAL) |
        ({29'h0, nch} << MPS_ST_CNT_LSB));
    wire [31:0] rd_mux = hit_per ? {16'h0, period_reg} :
                         hit_max ? {16'h0, maxon_reg} :
                         hit_st  ? status_word :
                         hit_avg ? 32'(avg_reg) : 32'h0;

    always_ff @(posedge clk) begin
        if (reset) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            prdata_reg  <= (acc && !pready_reg && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // a zero period would stretch the timer to 65536 cycles, so it is floored at one
    always_ff @(posedge clk) begin
        if (reset) begin
            period_reg <= MPS_PERIOD_RST;
            maxon_reg  <= MPS_MAXON_RST;
        end else if (wr_done && hit_per) begin
            period_reg <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
        end else if (wr_done && hit_max) begin
            maxon_reg  <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interval timer and per-channel phase offsets
    logic [15:0] cnt_reg;
    wire  [15:0] step = (nch == 3'h4) ? (period_reg >> 2) :  // R8
                        (nch == 3'h3) ? 16'(period_reg / 16'h3) : // R9
                        (nch == 3'h2) ? (period_reg >> 1) :  // R10
                                        period_reg;
    wire cyc_wrap = (cnt_reg >= period_reg - 16'h1);

    always_ff @(posedge clk) begin
        if (reset || !run_reg) begin
            cnt_reg <= 16'h0;
        end else begin
            cnt_reg <= cyc_wrap ? 16'h0 : cnt_reg + 16'h1;   // R1
        end
    end

    wire [MPS_CH-1:0] start;
    generate
        for (g = 0; g < MPS_CH; g++) begin : g_start
            // channel g opens its interval g steps after channel one
            assign start[g] = (cnt_reg == 16'(step * 16'(g))); // R8 R9 R10
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // current balance, refreshed once per switching cycle
    localparam int EW = CW + 2;
    logic [CW-1:0]         samp_reg [MPS_CH];
    logic signed [EW-1:0]  filt_reg [MPS_CH];
    logic [CW+1:0]         sum;

    always_comb begin
        sum = '0;
        for (int i = 0; i < MPS_CH; i++) begin
            if (active[i]) begin                             // R20
                sum = sum + (CW+2)'(cur_s2_reg[i*CW +: CW]); // R12
            end
        end
    end

    wire [CW+1:0] avg_full = (nch == 3'h4) ? (sum >> 2) :
                             (nch == 3'h3) ? (CW+2)'(sum / 3'h3) :
                             (nch == 3'h2) ? (sum >> 1) : sum;

    always_ff @(posedge clk) begin
        if (reset || !run_reg) begin
            avg_reg <= '0;
            for (int i = 0; i < MPS_CH; i++) begin
                samp_reg[i] <= '0;
                filt_reg[i] <= '0;
            end
        end else if (cyc_wrap) begin                         // R7
            avg_reg <= avg_full[CW-1:0];                     // R12
            for (int i = 0; i < MPS_CH; i++) begin
                // idle channels keep their sense path quiet
                samp_reg[i] <= active[i] ? cur_s2_reg[i*CW +: CW] : '0; // R11
                // signed operands keep the shift arithmetic when low
                filt_reg[i] <= filt_reg[i] +
                    ((signed'(EW'(samp_reg[i])) - signed'(EW'(avg_reg))
                      - filt_reg[i]) >>> MPS_FILT_SH);       // R13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pulse logic: heavier channels get a shorter on-time ceiling
    logic [MPS_CH-1:0] fired_reg;
    logic [15:0]       on_cnt_reg [MPS_CH];
    logic [MPS_CH-1:0] drive_next, fired_next;
    logic signed [17:0] lim;

    always_comb begin
        lim = '0;
        for (int i = 0; i < MPS_CH; i++) begin
            lim = 18'(maxon_reg) - 18'(filt_reg[i] >>> MPS_TRIM_SH); // R13
            drive_next[i] = 1'b0;
            fired_next[i] = fired_reg[i];
            if (!run_reg || !active[i]) begin                // R14 R20
                drive_next[i] = 1'b0;
                fired_next[i] = 1'b0;
            end else if (apa_s) begin                        // R5
                drive_next[i] = 1'b1;
                fired_next[i] = 1'b1;
            end else if (start[i]) begin
                drive_next[i] = cross_s2_reg[i];             // R2
                fired_next[i] = cross_s2_reg[i];
            end else if (drive_reg[i]) begin
                // signed compare: a ceiling below zero ends the pulse
                drive_next[i] = cross_s2_reg[i] &&
                    (signed'(18'(on_cnt_reg[i])) < lim);     // R2 R13
            end else begin
                drive_next[i] = cross_s2_reg[i] && !fired_reg[i]; // R4
                fired_next[i] = fired_reg[i] || cross_s2_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            drive_reg <= '0;
            fired_reg <= '0;
            for (int i = 0; i < MPS_CH; i++) begin
                on_cnt_reg[i] <= 16'h0;
            end
        end else begin
            drive_reg <= drive_next;                         // R3
            fired_reg <= fired_next;
            for (int i = 0; i < MPS_CH; i++) begin
                on_cnt_reg[i] <= drive_next[i] ?
                    on_cnt_reg[i] + 16'h1 : 16'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // regulator enables
    logic core_en_reg, nb_en_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            core_en_reg <= 1'b0;
            nb_en_reg   <= 1'b0;
        end else begin
            core_en_reg <= run_reg;                          // R14
            nb_en_reg   <= run_reg && serial_reg;            // R19
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign phase1_drive       = drive_reg[0];
    assign phase2_drive       = drive_reg[1];
    assign phase3_drive       = drive_reg[2];
    assign phase4_drive       = drive_reg[3];
    assign core_enable        = core_en_reg;
    assign nb_enable          = nb_en_reg;
    assign serial_code_mode   = serial_reg;
    assign parallel_code_mode = parallel_reg;
endmodule

// ### bench/mps_power_stage.sv
`timescale 1ns/1ns
module mps_power_stage
    import mps_pkg::*;
#(
    parameter int CW = 12
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [MPS_CH-1:0]    drive,
    output logic      [MPS_CH*CW-1:0] ch_current
);
    // high side on ramps the current; the freewheel is lossless here
    // so that a stage at rest shows a steady sample
    always_ff @(posedge clk) begin
        for (int k = 0; k < MPS_CH; k++) begin
            if (reset)
                ch_current[k*CW +: CW] <= CW'(8 * (k + 1));
            else if (drive[k] && ch_current[k*CW +: CW] != '1)
                ch_current[k*CW +: CW] <= ch_current[k*CW +: CW] + 1'h1;
        end
    end
endmodule

// ### bench/mps_checker_assertions.sv
`timescale 1ns/1ns
module mps_checker
    import mps_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset,
    input wire logic [MPS_CH-1:0] modulator_cross,
    input wire logic              transient_phase_alignment,
    input wire logic              ch4_sense_neg,
    input wire logic              enable,
    input wire logic              mode_select_pin,
    input wire logic              phase1_drive,
    input wire logic              phase4_drive,
    input wire logic              core_enable,
    input wire logic              nb_enable,
    input wire logic              serial_code_mode,
    input wire logic              parallel_code_mode
);
    // pins pass two sync stages and a register, hence the lags below
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire logic       idle1 = !modulator_cross[0] && !transient_phase_alignment;
    wire logic       force_on = transient_phase_alignment && core_enable;
    wire logic [1:0] modes = {serial_code_mode, parallel_code_mode};
    wire logic       any_on = core_enable || nb_enable || (|modes);
    property p_idle; idle1[*5] |-> !phase1_drive; endproperty
    a_idle: assert property (p_idle) else $error("drive without cross");
    property p_force; force_on[*4] |-> ##[0:2] phase1_drive; endproperty
    a_force: assert property (p_force) else $error("no forced drive");
    property p_off; !enable[*5] |-> !any_on; endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_hold; enable[*8] |-> $stable(modes); endproperty
    a_hold: assert property (p_hold) else $error("mode changed");
    property p_ser;
        $rose(serial_code_mode) |-> !$past(mode_select_pin, 4);
    endproperty
    a_ser: assert property (p_ser) else $error("serial on high select");
    property p_par;
        $rose(parallel_code_mode) |-> $past(mode_select_pin, 4);
    endproperty
    a_par: assert property (p_par) else $error("parallel on low select");
    property p_nb; parallel_code_mode |-> !nb_enable; endproperty
    a_nb: assert property (p_nb) else $error("second regulator on");
    property p_inact; ch4_sense_neg[*5] |-> !phase4_drive; endproperty
    a_inact: assert property (p_inact) else $error("unused phase on");
endmodule

// ### bench/mps_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin \
    total_checks++; \
    if ((s) !== (e)) begin \
        fail_count++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, s); \
    end \
end
module mps_sequencer_tb;
    import mps_pkg::*;
    logic        clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, enable = 1'h0, mode_select_pin = 1'h0;
    logic        transient_phase_alignment = 1'h0, ch2_sense_neg = 1'h0;
    logic        ch3_sense_neg = 1'h0, ch4_sense_neg = 1'h0, rec = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  modulator_cross = 4'h0, drv, drv_d, modes;
    logic [47:0] ch_current;
    logic        pready, pslverr, er, sel, core_enable, nb_enable;
    logic        phase1_drive, phase2_drive, phase3_drive, phase4_drive;
    logic        serial_code_mode, parallel_code_mode;
    int          fail_count = 0, total_checks = 0, p, s0, d, cyc = 0;
    int          first[4], rises[4];
    assign drv = {phase4_drive, phase3_drive, phase2_drive, phase1_drive};
    assign modes = {core_enable, nb_enable, serial_code_mode,
                    parallel_code_mode};
    always #10 clk = ~clk;
    mps_sequencer i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .modulator_cross,
        .transient_phase_alignment, .ch2_sense_neg, .ch3_sense_neg,
        .ch4_sense_neg, .ch_current, .enable, .mode_select_pin,
        .phase1_drive, .phase2_drive, .phase3_drive, .phase4_drive,
        .core_enable, .nb_enable, .serial_code_mode, .parallel_code_mode);
    mps_power_stage i_ps (.clk, .reset, .drive(drv), .ch_current);
    ////////////////////////////////////////////////////////////////////////
    // rise times per phase, the reference for order and spacing
    always @(posedge clk) begin
        cyc++;
        for (int k = 0; k < 4; k++)
            if (rec && drv[k] && !drv_d[k]) begin
                if (rises[k] == 0) first[k] = cyc;
                rises[k]++;
            end
        drv_d = drv;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] dat);
        @(posedge clk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dat;
        @(posedge clk);
        penable <= 1'h1;
        // no wait count assumed here: the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(58));
        p = 12 * (4 + $urandom % 3);
        s0 = $urandom % 2;
        wt(16);
        reset <= 1'h0;
        apb(1'h0, MPS_OFS_PERIOD, 32'h0);
        `CHK("period_rst", 32'h190, rd)
        apb(1'h0, MPS_OFS_MAXON, 32'h0);
        `CHK("maxon_rst", 32'h140, rd)
        apb(1'h1, MPS_OFS_PERIOD, 32'(p));
        apb(1'h1, MPS_OFS_MAXON, 32'(p / 2));
        apb(1'h0, MPS_OFS_PERIOD, 32'h0);
        `CHK("period", 32'(p), rd)
        apb(1'h1, 8'h20, 32'h0);
        `CHK("unmapped", 1'h1, er)
        apb(1'h1, MPS_OFS_STATUS, 32'hffff);
        `CHK("ro_write", 1'h0, er)
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            sel = 1'(s0 ^ i);
            enable <= 1'h0;
            mode_select_pin <= sel;
            wt(MPS_SEL_SETUP_CYC + 10);
            `CHK("off", 4'h0, modes)
            enable <= 1'h1;
            wt(10);
            `CHK("mode", {1'h1, !sel, !sel, sel}, modes)
            mode_select_pin <= !sel;
            wt(10);
            apb(1'h0, MPS_OFS_STATUS, 32'h0);
            `CHK("st_mode", {1'h1, sel, !sel}, rd[6:4])
        end
        $display("test mode done");
        for (int n = 4; n > 0; n--) begin
            ch4_sense_neg <= (n < 4);
            ch3_sense_neg <= (n < 3);
            ch2_sense_neg <= (n < 2);
            wt(3 * p);
            apb(1'h0, MPS_OFS_STATUS, 32'h0);
            `CHK("count", 3'(n), rd[2:0])
            apb(1'h0, MPS_OFS_AVG, 32'h0);
            `CHK("avg", 32'(4 * (n + 1)), rd)
        end
        $display("test balance done");
        modulator_cross <= 4'hf;
        ch2_sense_neg <= 1'h0;
        for (int n = 4; n > 1; n--) begin
            ch4_sense_neg <= (n < 4);
            ch3_sense_neg <= (n < 3);
            wt(2 * p);
            rises = '{default: 0};
            rec <= 1'h1;
            wt(4 * p);
            rec <= 1'h0;
            wt(1);
            for (int k = 0; k < 4; k++) begin
                d = ((first[k] - first[0]) % p + p) % p;
                `CHK("rises", (k < n) ? 4 : 0, rises[k])
                if (k > 0 && k < n)
                    `CHK("offset", k * p / n, d)
            end
        end
        $display("test interleave done");
        modulator_cross <= 4'h0;
        wt(p);
        transient_phase_alignment <= 1'h1;
        wt(5);
        `CHK("align", 4'h3, drv)
        transient_phase_alignment <= 1'h0;
        $display("test align done");
        summarize;
    end
    initial begin
        #800000;
        fail_count++;
        summarize;
    end
endmodule
bind mps_sequencer mps_checker i_chk (.clk, .reset, .modulator_cross,
    .transient_phase_alignment, .ch4_sense_neg, .enable, .mode_select_pin,
    .phase1_drive, .phase4_drive, .core_enable, .nb_enable,
    .serial_code_mode, .parallel_code_mode);
